// ===== rtl/pid_pkg.sv
// Shared constants and types for the processor identification block.
// Assumes a single clock domain and a plain strobe register port.
package pid_pkg;

  // Register port widths.
  localparam int unsigned PID_AW = 8;
  localparam int unsigned PID_DW = 32;

  // Register byte offsets.
  localparam logic [7:0] PID_OFF_FLAGS   = 8'h00;  // Flags word, pop on write, push on read.
  localparam logic [7:0] PID_OFF_CFG     = 8'h04;  // Mode, privilege and generation straps.
  localparam logic [7:0] PID_OFF_SEL     = 8'h08;  // Selector register.
  localparam logic [7:0] PID_OFF_EXEC    = 8'h0c;  // A write while the sequencer is idle issues the query, or faults when the query strap is clear.
  localparam logic [7:0] PID_OFF_RES_A   = 8'h10;  // Result register a.
  localparam logic [7:0] PID_OFF_RES_B   = 8'h14;  // Result register b.
  localparam logic [7:0] PID_OFF_RES_C   = 8'h18;  // Result register c.
  localparam logic [7:0] PID_OFF_RES_D   = 8'h1c;  // Result register d.
  localparam logic [7:0] PID_OFF_STAT    = 8'h20;  // Sticky events, cleared by a read.
  localparam logic [7:0] PID_OFF_MASK    = 8'h24;  // Interrupt mask, same layout.
  localparam logic [7:0] PID_OFF_FPU_CMD = 8'h28;  // Floating-point reset and env store.
  localparam logic [7:0] PID_OFF_FPU_E0  = 8'h2c;  // Stored env: status high, control low.
  localparam logic [7:0] PID_OFF_FPU_E1  = 8'h30;  // Stored env: tag word low.
  localparam logic [7:0] PID_OFF_FPU_INF = 8'h34;  // Infinity patterns: negative high.

  // Flags word fields.
  localparam int unsigned PID_FL_QUERY = 21;
  localparam int unsigned PID_FL_ALIGN = 18;
  localparam int unsigned PID_FL_B15   = 15;
  localparam int unsigned PID_FL_NEST  = 14;
  localparam int unsigned PID_FL_IO_PRIVILEGE_FIELD  = 12;
  localparam logic [31:0] PID_FL_RESET = 32'h0000_0002;
  localparam logic [31:0] PID_FL_FIXED1 = 32'h0000_0002;
  localparam logic [31:0] PID_FL_LOWMASK = 32'h0000_0fd5;

  // Configuration fields.
  localparam int unsigned PID_CFG_PROT  = 0;
  localparam int unsigned PID_CFG_CPL   = 1;
  localparam int unsigned PID_CFG_QIMPL = 3;
  localparam int unsigned PID_CFG_AIMPL = 4;
  localparam logic [4:0]  PID_CFG_RESET = 5'h18;

  // Status and mask fields.
  localparam int unsigned PID_ST_DONE  = 0;
  localparam int unsigned PID_ST_FAULT = 1;
  localparam int unsigned PID_ST_ENV   = 2;
  localparam int unsigned PID_ST_W     = 3;
  localparam int unsigned PID_ST_BUSY  = 8;

  // Floating-point command bits and initial state.
  localparam int unsigned PID_FC_RESET = 0;
  localparam int unsigned PID_FC_STORE = 1;
  localparam logic [15:0] PID_FPU_CW_INIT = 16'h037f;
  localparam logic [15:0] PID_FPU_SW_INIT = 16'h0000;
  localparam logic [15:0] PID_FPU_TW_INIT = 16'hffff;
  localparam logic [15:0] PID_FPU_POS_INF = 16'h7ff0;
  localparam logic [15:0] PID_FPU_NEG_INF = 16'hfff0;

  // Highest leaf that the query answers.
  localparam logic [31:0] PID_MAX_LEAF = 32'h0000_0001;

  // Register port request.
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pid_bus_s;

  // The four result registers.
  typedef struct packed {
    logic [31:0] a;
    logic [31:0] b;
    logic [31:0] c;
    logic [31:0] d;
  } pid_result_s;

  // Query sequencer states.
  typedef enum logic [1:0] {PID_IDLE, PID_DRAIN, PID_LOOKUP, PID_CAPTURE} pid_state_e;

endpackage : pid_pkg

// ===== rtl/pid_leaf_rom.sv
// Leaf table for the processor query: one 128-bit entry per leaf.
// Assumes the caller keeps the leaf index in range; read data is registered.
`timescale 1ns/1ns
`default_nettype none
module pid_leaf_rom #(
  parameter logic [31:0] VENDOR_B  = 32'h6d617845,  // Arbitrary vendor text, part one.
  parameter logic [31:0] VENDOR_D  = 32'h43656c70,  // Arbitrary vendor text, part two.
  parameter logic [31:0] VENDOR_C  = 32'h3165726f,  // Arbitrary vendor text, part three.
  parameter logic [31:0] SIGNATURE = 32'h0000_0400,  // Arbitrary signature value.
  parameter logic [31:0] FEATURES  = 32'h0000_0001   // Feature flags answered for leaf one.
) (
  input  wire logic                 clk_sys,
  input  wire logic                 sys_rst,
  input  wire logic                 rd_en,
  input  wire logic                 leaf,
  output pid_pkg::pid_result_s      rdata
);
  import pid_pkg::*;

  // Constant table; leaf zero spreads the vendor text over b, d, c.
  wire pid_result_s entry0 = '{a: PID_MAX_LEAF, b: VENDOR_B, c: VENDOR_C, d: VENDOR_D};
  wire pid_result_s entry1 = '{a: SIGNATURE, b: 32'h0000_0000, c: 32'h0000_0000, d: FEATURES};
  wire pid_result_s entry  = leaf ? entry1 : entry0;

  // Registered read port keeps the table out of the result timing path.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata <= '0;
    end else if (rd_en) begin
      rdata <= entry;
    end
  end
endmodule : pid_leaf_rom
`default_nettype wire

// ===== rtl/pid_fpu_unit.sv
// Floating-point control state used for presence and type detection.
// Assumes reset and store commands are one-cycle pulses.
`timescale 1ns/1ns
`default_nettype none
module pid_fpu_unit (
  input  wire logic        clk_sys,
  input  wire logic        sys_rst,
  input  wire logic        do_reset,
  input  wire logic        do_store,
  output logic      [47:0] env,
  output logic             stored,
  output logic      [31:0] inf_pair
);
  import pid_pkg::*;

  logic [47:0] live;  // Control, status and tag words as the unit holds them.

  // The reset instruction loads the initial words; a store copies them out.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      live     <= {PID_FPU_TW_INIT, PID_FPU_SW_INIT, PID_FPU_CW_INIT};
      env      <= '0;
      stored   <= 1'b0;
      inf_pair <= '0;
    end else begin
      stored <= do_store;
      if (do_reset) begin
        live     <= {PID_FPU_TW_INIT, PID_FPU_SW_INIT, PID_FPU_CW_INIT};
        inf_pair <= {PID_FPU_NEG_INF, PID_FPU_POS_INF};
      end
      if (do_store) begin
        env <= live;
      end
    end
  end
endmodule : pid_fpu_unit
`default_nettype wire

// ===== rtl/pid_ident.sv
// Processor identification block: flags word, query instruction, fpu checks.
// Assumes a plain strobe register port and a core that reports older work.
`timescale 1ns/1ns
`default_nettype none
module pid_ident #(
  parameter logic [31:0] VENDOR_B  = 32'h6d617845,  // Arbitrary vendor value.
  parameter logic [31:0] VENDOR_D  = 32'h43656c70,  // Arbitrary vendor value.
  parameter logic [31:0] VENDOR_C  = 32'h3165726f,  // Arbitrary vendor value.
  parameter logic [31:0] SIGNATURE = 32'h0000_0400,  // Arbitrary signature value.
  parameter logic [31:0] FEATURES  = 32'h0000_0001   // Feature flags for leaf one.
) (
  input  wire logic               clk_sys,
  input  wire logic               sys_rst,
  input  wire pid_pkg::pid_bus_s  bus_req,
  output logic             [31:0] bus_rdata,
  input  wire logic               older_ops_busy,
  output logic                    hold_younger,
  output logic                    invalid_opcode_fault,
  output logic                    irq
);
  import pid_pkg::*;

  // Architectural and control state.
  logic [31:0]         flags_word;        // Flags word as a push would see it.
  logic [4:0]          cfg;               // Mode, level and generation controls.
  logic [31:0]         selector_register; // Leaf chosen by software.
  logic [31:0]         sel_lat;           // Leaf captured when the query issues.
  pid_result_s         result;            // Result registers a to d.
  logic [PID_ST_W-1:0] status;            // Sticky event bits.
  logic [PID_ST_W-1:0] mask;              // Interrupt enables.
  pid_state_e          state;             // Query sequencer.
  logic                in_range;          // Captured leaf is answered by the table.

  // Submodule outputs.
  pid_result_s rom_data;                  // Registered table entry.
  logic [47:0] fpu_env;                   // Last stored fpu environment.
  logic        fpu_stored;                // Pulse one cycle after a store.
  logic [31:0] fpu_inf;                   // Infinity patterns after fpu reset.

  // Merges a popped word into the old one under a write mask.
  function automatic logic [31:0] pid_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [31:0] wmask);
    pid_merge = ((old_v & ~wmask) | (new_v & wmask)) | PID_FL_FIXED1;
  endfunction : pid_merge

  // Address decode for the register port.
  wire wr_flags = bus_req.wr && (bus_req.addr == PID_OFF_FLAGS);
  wire wr_cfg   = bus_req.wr && (bus_req.addr == PID_OFF_CFG);
  wire wr_sel   = bus_req.wr && (bus_req.addr == PID_OFF_SEL);
  wire wr_exec  = bus_req.wr && (bus_req.addr == PID_OFF_EXEC);
  wire wr_mask  = bus_req.wr && (bus_req.addr == PID_OFF_MASK);
  wire wr_fcmd  = bus_req.wr && (bus_req.addr == PID_OFF_FPU_CMD);
  wire rd_stat  = bus_req.rd && (bus_req.addr == PID_OFF_STAT);

  // Mode and generation controls.
  wire       prot_mode = cfg[PID_CFG_PROT];
  wire [1:0] current_privilege_level       = cfg[PID_CFG_CPL +: 2];
  wire       q_impl    = cfg[PID_CFG_QIMPL];
  wire       ac_impl   = cfg[PID_CFG_AIMPL];

  // Real mode always runs at level zero, so only protected mode can deny.
  wire io_privilege_field_ok = !prot_mode || (current_privilege_level == 2'b00);

  // Write mask for the pop path; bit 15 is never writable, so it reads zero.
  wire [31:0] wmask_query = {10'h000, q_impl, 21'h000000};
  wire [31:0] wmask_align = {13'h0000, ac_impl, 18'h00000};
  wire [31:0] wmask_nest  = 32'h0000_0001 << PID_FL_NEST;
  wire [31:0] wmask_io_privilege_field  = io_privilege_field_ok ? (32'h0000_0003 << PID_FL_IO_PRIVILEGE_FIELD)
                                    : 32'h0000_0000;
  wire [31:0] flags_wmask = wmask_query | wmask_align | wmask_nest | wmask_io_privilege_field
                            | PID_FL_LOWMASK;

  // Next flags word: a pop commits by the next edge.
  wire [31:0] next_flags = wr_flags ? pid_merge(flags_word, bus_req.wdata, flags_wmask)
                                    : flags_word;

  // Query issue decisions.
  wire issue_ok    = wr_exec && (state == PID_IDLE) && q_impl;
  wire issue_fault = wr_exec && (state == PID_IDLE) && !q_impl;

  // The table answers leaves up to the highest one; others return zeros.
  wire leaf_in_range = (sel_lat <= PID_MAX_LEAF);

  // Events for the status register.
  wire [PID_ST_W-1:0] ev;
  assign ev[PID_ST_DONE]  = (state == PID_CAPTURE);
  assign ev[PID_ST_FAULT] = issue_fault;
  assign ev[PID_ST_ENV]   = fpu_stored;

  // A read clears the bits it saw; an event in the same cycle still sets.
  wire [PID_ST_W-1:0] next_status = (rd_stat ? '0 : status) | ev;

  // Read data selection; unmapped offsets answer zero.
  logic [31:0] next_rdata;
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (bus_req.addr)
      PID_OFF_FLAGS:   next_rdata = flags_word;
      PID_OFF_CFG:     next_rdata = {27'h0000000, cfg};
      PID_OFF_SEL:     next_rdata = selector_register;
      PID_OFF_RES_A:   next_rdata = result.a;
      PID_OFF_RES_B:   next_rdata = result.b;
      PID_OFF_RES_C:   next_rdata = result.c;
      PID_OFF_RES_D:   next_rdata = result.d;
      PID_OFF_STAT:    next_rdata = {23'h000000, (state != PID_IDLE), 5'h00, status};
      PID_OFF_MASK:    next_rdata = {29'h00000000, mask};
      PID_OFF_FPU_E0:  next_rdata = fpu_env[31:0];
      PID_OFF_FPU_E1:  next_rdata = {16'h0000, fpu_env[47:32]};
      PID_OFF_FPU_INF: next_rdata = fpu_inf;
      default:         next_rdata = 32'h0000_0000;
    endcase
  end

  // Sequencer next state: drain older work, read the table, capture.
  pid_state_e next_state;
  always_comb begin
    next_state = state;
    case (state)
      PID_IDLE: begin
        if (issue_ok) begin
          next_state = PID_DRAIN;
        end
      end
      PID_DRAIN: begin
        // Nothing younger moves until older operations have finished.
        if (!older_ops_busy) begin
          next_state = PID_LOOKUP;
        end
      end
      PID_LOOKUP: begin
        next_state = PID_CAPTURE;
      end
      PID_CAPTURE: begin
        next_state = PID_IDLE;
      end
      default: begin
        next_state = PID_IDLE;
      end
    endcase
  end

  // Younger work is held for the whole query, including the result write.
  assign hold_younger = (state != PID_IDLE);

  // Level interrupt from any unmasked sticky bit.
  assign irq = |(status & mask);

  // Table read fires in the lookup state; data are ready at capture.
  wire rom_rd = (state == PID_LOOKUP);

  // Leaf table.
  pid_leaf_rom #(
    .VENDOR_B  (VENDOR_B),
    .VENDOR_D  (VENDOR_D),
    .VENDOR_C  (VENDOR_C),
    .SIGNATURE (SIGNATURE),
    .FEATURES  (FEATURES)
  ) u_rom (
    .clk_sys (clk_sys),
    .sys_rst (sys_rst),
    .rd_en   (rom_rd),
    .leaf    (sel_lat[0]),
    .rdata   (rom_data)
  );

  // Floating-point state used for presence and type checks.
  pid_fpu_unit u_fpu (
    .clk_sys  (clk_sys),
    .sys_rst  (sys_rst),
    .do_reset (wr_fcmd && bus_req.wdata[PID_FC_RESET]),
    .do_store (wr_fcmd && bus_req.wdata[PID_FC_STORE]),
    .env      (fpu_env),
    .stored   (fpu_stored),
    .inf_pair (fpu_inf)
  );

  // Flags word, configuration and selector.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      flags_word        <= PID_FL_RESET;
      cfg               <= PID_CFG_RESET;
      selector_register <= 32'h0000_0000;
      mask              <= '0;
    end else begin
      flags_word <= next_flags;
      if (wr_cfg) begin
        cfg <= bus_req.wdata[4:0];
      end
      if (wr_sel) begin
        selector_register <= bus_req.wdata;
      end
      if (wr_mask) begin
        mask <= bus_req.wdata[PID_ST_W-1:0];
      end
    end
  end

  // Sequencer and captured leaf.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      state    <= PID_IDLE;
      sel_lat  <= 32'h0000_0000;
      in_range <= 1'b0;
    end else begin
      state <= next_state;
      if (issue_ok) begin
        sel_lat <= selector_register;
      end
      if (rom_rd) begin
        in_range <= leaf_in_range;
      end
    end
  end

  // Result registers are written only as the query completes.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      result <= '0;
    end else if (state == PID_CAPTURE) begin
      result <= in_range ? rom_data : '0;
    end
  end

  // Fault pulse, sticky status and registered read data.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      invalid_opcode_fault <= 1'b0;
      status               <= '0;
      bus_rdata            <= 32'h0000_0000;
    end else begin
      invalid_opcode_fault <= issue_fault;
      status               <= next_status;
      if (bus_req.rd) begin
        bus_rdata <= next_rdata;
      end else begin
        bus_rdata <= 32'h0000_0000;
      end
    end
  end

endmodule : pid_ident
`default_nettype wire

// ===== verif/pid_monitor.sv
// Port-level checker for the processor identification block.
// Assumes it is bound to pid_ident and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
module pid_monitor (
  input  wire logic              clk_sys,
  input  wire logic              sys_rst,
  input  wire pid_pkg::pid_bus_s bus_req,
  input  wire logic       [31:0] bus_rdata,
  input  wire logic              older_ops_busy,
  input  wire logic              hold_younger,
  input  wire logic              invalid_opcode_fault,
  input  wire logic              irq
);
  import pid_pkg::*;
  logic       qimpl;  // Mirror of the query-implemented strap.
  logic [2:0] mask;   // Mirror of the interrupt mask.
  logic       exec;   // A query issue written while the sequencer is idle.
  assign exec = bus_req.wr && bus_req.addr == PID_OFF_EXEC && !hold_younger;
  // The mirrors track software writes, since the straps are not visible as ports.
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      qimpl <= 1'b1;
      mask  <= 3'h0;
    end else begin
      if (bus_req.wr && bus_req.addr == PID_OFF_CFG) begin
        qimpl <= bus_req.wdata[PID_CFG_QIMPL];
      end
      if (bus_req.wr && bus_req.addr == PID_OFF_MASK) begin
        mask <= bus_req.wdata[2:0];
      end
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Read data stands only in the slot after a read strobe.
  a_rdata_idle: assert property (!$past(bus_req.rd) |-> bus_rdata == 32'h0)
    else $error("read data outside its slot");
  a_flags_fixed: assert property ($past(bus_req.rd) && $past(bus_req.addr) == PID_OFF_FLAGS
    |-> (bus_rdata & 32'hffdb_8002) == 32'h0000_0002) else $error("fixed flag bits wrong");
  a_query_start: assert property (exec && qimpl |=> hold_younger ##1 hold_younger)
    else $error("query did not hold younger work");
  a_fault_pulse: assert property (exec && !qimpl |=> invalid_opcode_fault ##1
    !invalid_opcode_fault) else $error("missing fault pulse");
  a_fault_cause: assert property (invalid_opcode_fault |-> $past(bus_req.wr) &&
    $past(bus_req.addr) == PID_OFF_EXEC && !$past(qimpl)) else $error("fault without cause");
  a_drain_wait: assert property ($rose(hold_younger) && older_ops_busy |=> hold_younger)
    else $error("query left drain early");
  a_hold_len: assert property ($rose(hold_younger) && !older_ops_busy |->
    hold_younger[*3] ##1 !hold_younger) else $error("query length wrong");
  a_irq_mask: assert property (mask == 3'h0 |-> !irq) else $error("masked interrupt seen");
  a_inf_split: assert property ($past(bus_req.rd) && $past(bus_req.addr) == PID_OFF_FPU_INF &&
    bus_rdata != 32'h0 |-> bus_rdata[31:16] != bus_rdata[15:0]) else $error("infinities equal");
endmodule : pid_monitor
bind pid_ident pid_monitor u_mon (.clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req),
  .bus_rdata(bus_rdata), .older_ops_busy(older_ops_busy), .hold_younger(hold_younger),
  .invalid_opcode_fault(invalid_opcode_fault), .irq(irq));
`default_nettype wire

// ===== verif/tb_top.sv
// Self-checking bench for the processor identification block.
// Assumes read data one cycle after the strobe, as the block hands it over.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
  import pid_pkg::*;
  localparam logic [31:0] VB = 32'h1357_9bdf;  // Arbitrary vendor text.
  localparam logic [31:0] VD = 32'h2468_ace0;  // Arbitrary vendor text.
  localparam logic [31:0] VC = 32'h0f1e_2d3c;  // Arbitrary vendor text.
  localparam logic [31:0] SG = 32'h0000_0512;  // Arbitrary signature.
  localparam logic [31:0] FT = 32'h0000_0081;  // Arbitrary feature set.
  logic        clk_sys = 1'b0;
  logic        sys_rst = 1'b1;
  pid_bus_s    bus_req = '0;
  logic [31:0] bus_rdata;
  logic        older_ops_busy = 1'b0;
  logic        hold_younger;
  logic        invalid_opcode_fault;
  logic        irq;
  int          error_cnt = 0;
  int          comparisons = 0;
  int          seed = 37652;
  logic [31:0] flags_m = 32'h2;  // Model of the flags word.
  logic [4:0]  cfg_m = 5'h18;    // Model of the straps.
  logic [31:0] v;                // Scratch read value.
  logic [31:0] sels [4] = '{32'h0, 32'h1, 32'h2, 32'h8000_0000};
  pid_result_s ex;               // Expected query results.
  pid_ident #(.VENDOR_B(VB), .VENDOR_D(VD), .VENDOR_C(VC), .SIGNATURE(SG), .FEATURES(FT)) dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .older_ops_busy(older_ops_busy), .hold_younger(hold_younger),
    .invalid_opcode_fault(invalid_opcode_fault), .irq(irq));
  // Free-running clock at 4 ns.
  always #2 clk_sys = ~clk_sys;
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  // One write cycle, then an idle cycle so no strobe is driven twice at one edge.
  task automatic bw(input logic [7:0] a, input logic [31:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    bus_req <= '0;
    @(posedge clk_sys);
  endtask : bw
  // One read cycle; the data are taken in the single slot after the strobe.
  task automatic br(input logic [7:0] a, output logic [31:0] d);
    bus_req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    bus_req <= '0;
    #1;
    d = bus_rdata;
    @(posedge clk_sys);
  endtask : br
  // Pop-path model: which bits a flags write may change under the current straps.
  function automatic logic [31:0] pop(input logic [31:0] o, input logic [31:0] n);
    logic [31:0] m;
    m = 32'h0000_4fd5;
    if (!cfg_m[0] || cfg_m[2:1] == 2'h0) m = m | 32'h0000_3000;
    if (cfg_m[4]) m = m | 32'h0004_0000;
    if (cfg_m[3]) m = m | 32'h0020_0000;
    return (o & ~m) | (n & m) | 32'h2;
  endfunction : pop
  task automatic results;
    if (error_cnt == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : results
  // Watchdog at 50000 cycles; the sequence needs well under that.
  initial begin
    #200000;
    error_cnt++;
    results();
  end
  initial begin
    repeat (8) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(posedge clk_sys);
    br(PID_OFF_FLAGS, v);
    chk(v, 32'h2);
    br(PID_OFF_CFG, v);
    chk(v, 32'h18);
    br(8'h3c, v);
    chk(v, 32'h0);
    // Random straps and flag values cover every mode, level and implemented flag.
    for (int i = 0; i < 32; i++) begin
      v = $random(seed);
      cfg_m = v[4:0];
      bw(PID_OFF_CFG, {27'h0, cfg_m});
      v = $random(seed);
      bw(PID_OFF_FLAGS, v);
      flags_m = pop(flags_m, v);
      br(PID_OFF_FLAGS, v);
      chk(v, flags_m);
    end
    cfg_m = 5'h18;
    bw(PID_OFF_CFG, 32'h18);
    bw(PID_OFF_MASK, 32'h7);
    // Each leaf runs while older work is still draining.
    for (int l = 0; l < 4; l++) begin
      ex = '0;
      if (sels[l] == 32'h0) ex = '{a: 32'h1, b: VB, c: VC, d: VD};
      if (sels[l] == 32'h1) ex = '{a: SG, b: 32'h0, c: 32'h0, d: FT};
      bw(PID_OFF_SEL, sels[l]);
      older_ops_busy <= 1'b1;
      bw(PID_OFF_EXEC, $random(seed));
      repeat (3) @(posedge clk_sys);
      #1;
      chk({31'h0, hold_younger}, 32'h1);
      // Back onto the rising edge so every input change is made there.
      @(posedge clk_sys);
      older_ops_busy <= 1'b0;
      for (int k = 0; k < 20; k++) begin
        @(posedge clk_sys);
        #1;
        if (hold_younger !== 1'b1) break;
      end
      chk({31'h0, hold_younger}, 32'h0);
      chk({31'h0, irq}, 32'h1);
      @(posedge clk_sys);
      for (int j = 0; j < 4; j++) begin
        br(PID_OFF_RES_A + 8'(4 * j), v);
        chk(v, ex[127 - 32 * j -: 32]);
      end
      br(PID_OFF_STAT, v);
      chk(v, 32'h1);
      #1;
      chk({31'h0, irq}, 32'h0);
      @(posedge clk_sys);
    end
    // Without query support the issue faults; the fault event is masked here.
    bw(PID_OFF_CFG, 32'h10);
    bw(PID_OFF_MASK, 32'h5);
    bw(PID_OFF_EXEC, 32'h0);
    #1;
    chk({31'h0, irq}, 32'h0);
    @(posedge clk_sys);
    br(PID_OFF_STAT, v);
    chk(v, 32'h2);
    bw(PID_OFF_FPU_CMD, 32'h1);
    bw(PID_OFF_FPU_CMD, 32'h2);
    br(PID_OFF_FPU_E0, v);
    chk(v, {PID_FPU_SW_INIT, PID_FPU_CW_INIT});
    br(PID_OFF_FPU_E1, v);
    chk(v, {16'h0, PID_FPU_TW_INIT});
    br(PID_OFF_FPU_INF, v);
    chk(v, {PID_FPU_NEG_INF, PID_FPU_POS_INF});
    chk({31'h0, irq}, 32'h1);
    br(PID_OFF_STAT, v);
    chk(v, 32'h4);
    results();
  end
endmodule : tb_top
`default_nettype wire
